/* File: szp_consts.vh */
// constants for the slot write and zone lock policy checker
// assumes inclusion by szp_policy.v only; all values are `define macros
//
// What this block does
// - write policy bits 15:12, pointer 11:8
// - bit 7 marks slot secret, no clear reads
// - policy 000x allows clear writes, 4 or 32
// - policy 001x or 10xx refuses all writes
// - bit 14: encrypted MAC writes, no 4-byte
// - bit 13 zero: no key derivation target
// - bit 12 selects roll or create source
// - bit 15 demands authorising MAC for derivation
// - create takes key from target's pointer slot
// - secret slot rejects 4-byte reads and writes
// - self-pointing encrypted write authenticates with current key
// - config bytes 0-12 never written, always read
// - id: 24 fixed bits always hashed, low 32 of the 48 die bits optional
// - lock bytes 87/86 changed only by lock
// - lock value 0x55 means unlocked
// - config writes only while unlocked, reads always
// - data/one-time access errors before config lock
// - data: write-only unlocked, policy-limited after lock
// - one-time zone write-only between the locks
// - read-only one-time mode: reads after both locks, writes between them still pass
// - legacy mode: words 0,1 hidden, 4-byte reads
// - unprogrammed one-time bits read as one
// - revision bytes always readable
`ifndef SZP_CONSTS_VH
`define SZP_CONSTS_VH
`define SZP_REG_CMD 8'h00
`define SZP_REG_ARG 8'h04
`define SZP_REG_RESULT 8'h08
`define SZP_REG_SLOTSEL 8'h0C
`define SZP_REG_POLICY 8'h10
`define SZP_REG_OTP_POLICY 8'h14
`define SZP_REG_DATA_LOCK 8'h56
`define SZP_REG_CFG_LOCK 8'h57
`define SZP_REG_OTPWORD 8'h18
`define SZP_REG_HASHSEL 8'h1C
`define SZP_UNLOCKED 8'h55
`define SZP_LOCKED 8'h00
`define SZP_OTP_READONLY 8'hAA
`define SZP_OTP_LEGACY 8'h00
`define SZP_OTP_ERASED 32'hFFFF_FFFF
`define SZP_CFG_FIXED_LAST 7'h0C
`define SZP_CFG_REV_FIRST 7'h04
`define SZP_CFG_REV_LAST 7'h07
`define SZP_CFG_LOCKDATA_ADDR 7'h56
`define SZP_CFG_LOCKCFG_ADDR 7'h57
`define SZP_OP_READ 3'h0
`define SZP_OP_WRITE 3'h1
`define SZP_OP_DERIVE 3'h2
`define SZP_OP_LOCK_CFG 3'h3
`define SZP_OP_LOCK_DATA 3'h4
`define SZP_ZONE_CFG 2'h0
`define SZP_ZONE_OTP 2'h1
`define SZP_ZONE_DATA 2'h2
`define SZP_WP_MSB 15
`define SZP_WP_LSB 12
`define SZP_PTR_MSB 11
`define SZP_PTR_LSB 8
`define SZP_SECRET_BIT 7
`define SZP_ST_OK 8'h00
`define SZP_ST_ERR 8'h0F
`define SZP_ID_FIXED_BITS 24
`define SZP_ID_DIE_BITS 48
`endif

/* File: szp_policy.v */
// slot write and zone lock permission checker behind an avalon-mm slave
// assumes a master that holds requests until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
`include "szp_consts.vh"
module szp_policy #(
  parameter SLOTS = 16,
  parameter OTP_WORDS = 16,
  parameter [23:0] ID_FIXED = 24'h5A_A5C3
) (
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [31:0] hashIdWord,
  output reg [23:0] hashIdFixed,
  output reg useDieId,
  output reg derivePermit,
  output reg deriveNeedsMac,
  output reg [3:0] deriveSourceSlot,
  output reg writeNeedsMac,
  output reg [3:0] writeAuthSlot
);

  // ID_FIXED: arbitrary value, stands in for the fixed id bits
  ////////////////////////////////////////////////////////////////////////
  reg [15:0] slotPolicyWord [0:SLOTS-1];
  reg [31:0] otpMem [0:OTP_WORDS-1];
  reg [7:0] configZoneLockByte;
  reg [7:0] dataZoneLockByte;
  reg [7:0] onePolicyByte;
  reg [47:0] dieId;
  reg [31:0] argReg;
  reg [3:0] slotSel;
  reg [7:0] status;
  reg [31:0] resultData;
  reg ack;
  reg [4:0] i;

  // argument fields: [2:0] op, [4:3] zone, [11:5] cfg byte, [8:5] otp word,
  // [15:12] slot, [16] long (32-byte), [17] encrypted+mac ok, [18] die id
  wire [2:0] op = argReg[2:0];
  wire [1:0] zone = argReg[4:3];
  wire [6:0] cfgAddr = argReg[11:5];
  wire [3:0] otpIdx = argReg[8:5];
  wire [3:0] slot = argReg[15:12];
  wire isLong = argReg[16];
  wire macOk = argReg[17];
  wire wantDieId = argReg[18];

  function unlockedByte;
    input [7:0] b;
    begin
      unlockedByte = (b == `SZP_UNLOCKED);
    end
  endfunction

  wire cfgUnlocked = unlockedByte(configZoneLockByte);
  wire dataUnlocked = unlockedByte(dataZoneLockByte);
  wire [15:0] tgtPol = slotPolicyWord[slot];
  wire [3:0] wp = tgtPol[`SZP_WP_MSB:`SZP_WP_LSB];
  wire [3:0] wptr = tgtPol[`SZP_PTR_MSB:`SZP_PTR_LSB];
  wire secret = tgtPol[`SZP_SECRET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // permission decode
  reg allow;
  always @* begin
    allow = 1'b0;
    case (op)
      `SZP_OP_READ: begin
        case (zone)
          `SZP_ZONE_CFG: allow = 1'b1;
          `SZP_ZONE_DATA:
            // secret slots are never clear-read here
            allow = !cfgUnlocked && !dataUnlocked && !secret &&
              (isLong || !secret);
          `SZP_ZONE_OTP: begin
            if (cfgUnlocked || dataUnlocked)
              allow = 1'b0;
            else if (onePolicyByte == `SZP_OTP_LEGACY)
              allow = !isLong && (otpIdx > 4'h1);
            else
              allow = (onePolicyByte == `SZP_OTP_READONLY);
          end
          default: allow = 1'b0;
        endcase
      end
      `SZP_OP_WRITE: begin
        case (zone)
          `SZP_ZONE_CFG:
            allow = cfgUnlocked && (cfgAddr > `SZP_CFG_FIXED_LAST) &&
              (cfgAddr != `SZP_CFG_LOCKDATA_ADDR) &&
              (cfgAddr != `SZP_CFG_LOCKCFG_ADDR);
          `SZP_ZONE_OTP:
            allow = !cfgUnlocked && dataUnlocked;
          `SZP_ZONE_DATA: begin
            if (cfgUnlocked)
              allow = 1'b0;
            else if (dataUnlocked)
              allow = 1'b1;
            else if (wp[2])
              allow = macOk && isLong;
            else if (wp[3:1] == 3'b000)
              allow = !secret || isLong;
            else
              allow = 1'b0;
          end
          default: allow = 1'b0;
        endcase
      end
      `SZP_OP_DERIVE:
        allow = !cfgUnlocked && !dataUnlocked && wp[1] &&
          (macOk || !wp[3]);
      `SZP_OP_LOCK_CFG: allow = cfgUnlocked;
      `SZP_OP_LOCK_DATA: allow = !cfgUnlocked && dataUnlocked;
      default: allow = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  // reads are looked up on the first edge, so readdata already stands
  // when waitrequest drops; writes land only on the edge that ends the
  // wait, so a master that gives up early changes nothing
  reg [4:0] j;
  wire busReq = read || write;
  wire wrTake = write && ack;
  wire rdLook = read && !ack;
  wire cmdTake = wrTake && (address == `SZP_REG_CMD);
  wire cmdPass = cmdTake && allow;
  wire cfgOpen = wrTake && cfgUnlocked;

  function regHit;
    input [7:0] a;
    input [7:0] r;
    begin
      regHit = (a == r);
    end
  endfunction

  function [31:0] byteWord;
    input [7:0] b;
    begin
      byteWord = {24'h00_0000, b};
    end
  endfunction

  // fixed single wait state, no timeout needed on our side
  assign waitrequest = busReq && !ack;

  ////////////////////////////////////////////////////////////////////////
  // handshake state
  always @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else if (clkEn) begin
      ack <= busReq && !ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command argument and slot select
  always @(posedge clk) begin
    if (sys_rst) begin
      argReg <= 32'h0000_0000;
      slotSel <= 4'h0;
    end else if (clkEn) begin
      if (wrTake && regHit(address, `SZP_REG_ARG)) begin
        argReg <= writedata;
      end
      if (wrTake && regHit(address, `SZP_REG_SLOTSEL)) begin
        slotSel <= writedata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // policy words, one-time policy and die id: frozen once config locks
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 5'h00; i < SLOTS; i = i + 5'h01) begin
        slotPolicyWord[i[3:0]] <= 16'h0000;
      end
      onePolicyByte <= `SZP_OTP_READONLY;
      dieId <= 48'h0000_0000_0000;
    end else if (clkEn) begin
      if (cfgOpen && regHit(address, `SZP_REG_POLICY)) begin
        slotPolicyWord[slotSel] <= writedata[15:0];
      end
      if (cfgOpen && regHit(address, `SZP_REG_OTP_POLICY)) begin
        onePolicyByte <= writedata[7:0];
      end
      if (cfgOpen && regHit(address, `SZP_REG_OTPWORD)) begin
        // die id shifts in a word at a time
        dieId <= {dieId[15:0], writedata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-time words
  always @(posedge clk) begin
    if (sys_rst) begin
      for (j = 5'h00; j < OTP_WORDS; j = j + 5'h01) begin
        otpMem[j[3:0]] <= `SZP_OTP_ERASED;
      end
    end else if (clkEn) begin
      if (cmdPass && (op == `SZP_OP_WRITE) && (zone == `SZP_ZONE_OTP)) begin
        // programming only clears bits, as a fuse array would
        otpMem[otpIdx] <= otpMem[otpIdx] & writedata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock bytes
  always @(posedge clk) begin
    if (sys_rst) begin
      configZoneLockByte <= `SZP_UNLOCKED;
      dataZoneLockByte <= `SZP_UNLOCKED;
    end else if (clkEn) begin
      // only the lock ops move these, and never back to open
      if (cmdPass && (op == `SZP_OP_LOCK_CFG)) begin
        configZoneLockByte <= `SZP_LOCKED;
      end
      if (cmdPass && (op == `SZP_OP_LOCK_DATA)) begin
        dataZoneLockByte <= `SZP_LOCKED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and result word
  always @(posedge clk) begin
    if (sys_rst) begin
      status <= `SZP_ST_OK;
      resultData <= 32'h0000_0000;
    end else if (clkEn) begin
      if (cmdTake) begin
        if (allow) begin
          status <= `SZP_ST_OK;
        end else begin
          status <= `SZP_ST_ERR;
        end
      end
      if (cmdPass && (op == `SZP_OP_READ)) begin
        if (zone == `SZP_ZONE_OTP) begin
          resultData <= otpMem[otpIdx];
        end else begin
          resultData <= {16'h0000, tgtPol};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write authorisation outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      writeNeedsMac <= 1'b0;
      writeAuthSlot <= 4'h0;
    end else if (clkEn) begin
      if (cmdTake) begin
        writeNeedsMac <= 1'b0;
      end
      if (cmdPass && (op == `SZP_OP_WRITE)) begin
        // a self pointer means the current key authenticates
        writeNeedsMac <= !dataUnlocked && wp[2];
        writeAuthSlot <= wptr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key derivation outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      derivePermit <= 1'b0;
      deriveNeedsMac <= 1'b0;
      deriveSourceSlot <= 4'h0;
    end else if (clkEn) begin
      if (cmdTake) begin
        derivePermit <= 1'b0;
      end
      if (cmdPass && (op == `SZP_OP_DERIVE)) begin
        derivePermit <= 1'b1;
        deriveNeedsMac <= wp[3];
        // create: parent via pointer; roll: the target
        if (wp[0]) begin
          deriveSourceSlot <= wptr;
        end else begin
          deriveSourceSlot <= slot;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // id bits handed to the hash engine
  always @(posedge clk) begin
    if (sys_rst) begin
      hashIdWord <= 32'h0000_0000;
      hashIdFixed <= 24'h00_0000;
      useDieId <= 1'b0;
    end else if (clkEn) begin
      if (cmdTake) begin
        hashIdFixed <= ID_FIXED;
        useDieId <= wantDieId;
        if (wantDieId) begin
          hashIdWord <= dieId[31:0];
        end else begin
          // die bits kept off the hash unless asked for
          hashIdWord <= 32'h0000_0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered on the first edge of a read
  always @(posedge clk) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (clkEn) begin
      if (rdLook) begin
        case (address)
          `SZP_REG_ARG: readdata <= argReg;
          `SZP_REG_RESULT: readdata <= resultData;
          `SZP_REG_CMD: readdata <= byteWord(status);
          `SZP_REG_SLOTSEL: readdata <= {28'h000_0000, slotSel};
          `SZP_REG_POLICY: readdata <= {16'h0000, slotPolicyWord[slotSel]};
          `SZP_REG_OTP_POLICY: readdata <= byteWord(onePolicyByte);
          `SZP_REG_DATA_LOCK: readdata <= byteWord(dataZoneLockByte);
          `SZP_REG_CFG_LOCK: readdata <= byteWord(configZoneLockByte);
          `SZP_REG_HASHSEL: readdata <= {8'h00, ID_FIXED};
          // unmapped addresses read as zero
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: szp_policy_asserts.sv */
// port-level relations of szp_policy
// assumes clkEn is held high throughout
`timescale 1ns/1ps
`default_nettype none
module szp_policy_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [31:0] hashIdWord,
  input wire logic useDieId,
  input wire logic derivePermit,
  input wire logic deriveNeedsMac,
  input wire logic [3:0] deriveSourceSlot
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cfgShut;
  logic dataShut;
  wire logic rdDone = read && !waitrequest;
  // a lock seen closed once may never read open again
  always @(posedge clk) begin
    if (sys_rst) begin
      cfgShut <= 1'b0;
      dataShut <= 1'b0;
    end else if (rdDone && readdata[7:0] != 8'h55) begin
      if (address == 8'h57) cfgShut <= 1'b1;
      if (address == 8'h56) dataShut <= 1'b1;
    end
  end
  a_wait_first: assert property (
    (read || write) && !$past(read || write) |-> waitrequest) else $error("no wait");
  a_wait_bound: assert property (
    (read || write) |-> ##[0:1] !waitrequest) else $error("wait too long");
  a_cfg_lock_once: assert property (
    rdDone && address == 8'h57 && cfgShut |-> readdata[7:0] != 8'h55)
    else $error("config lock reopened");
  a_data_lock_once: assert property (
    rdDone && address == 8'h56 && dataShut |-> readdata[7:0] != 8'h55)
    else $error("data lock reopened");
  a_die_gate: assert property (
    !useDieId |-> hashIdWord == 32'h0000_0000) else $error("die id leaked");
  a_outs_stand: assert property (
    !(read || write) |=> $stable({derivePermit, deriveNeedsMac, deriveSourceSlot}))
    else $error("result moved while idle");
  a_read_stand: assert property (
    !(read || write) |=> $stable(readdata)) else $error("readdata moved");
  a_unmapped_zero: assert property (
    rdDone && address == 8'hF0 |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind szp_policy szp_policy_asserts i_szp_policy_asserts (.clk, .sys_rst,
  .address, .read, .write, .readdata, .waitrequest, .hashIdWord, .useDieId,
  .derivePermit, .deriveNeedsMac, .deriveSourceSlot);
`default_nettype wire

/* File: szp_host_model.sv */
// host controller: one avalon-mm transfer per go request
// assumes go is held until done is seen
`timescale 1ns/1ps
`default_nettype none
module szp_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic goWr,
  input wire logic [7:0] goAddr,
  input wire logic [31:0] goData,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic read = 0,
  output logic write = 0,
  output logic [7:0] address = 0,
  output logic [31:0] writedata = 0,
  output logic done = 0,
  output logic [31:0] rdata = 0
);
  always @(posedge clk) begin
    done <= (read || write) && !waitrequest;
    if ((read || write) && !waitrequest) begin
      read <= 1'b0;
      write <= 1'b0;
      rdata <= readdata;
      // released lines must not keep looking valid
      address <= ~address;
      writedata <= ~writedata;
    end else if (go && !read && !write && !done) begin
      read <= !goWr;
      write <= goWr;
      address <= goAddr;
      writedata <= goData;
    end
  end
endmodule
`default_nettype wire

/* File: szp_policy_bench.sv */
// self-checking bench for szp_policy
// host model drives the bus; read results checked from a queue
`timescale 1ns/1ps
`default_nettype none
module szp_policy_bench;
  logic clk = 0, sys_rst = 1, go = 0, goWr = 0, read, write, waitrequest;
  logic done, useDieId, derivePermit, deriveNeedsMac, writeNeedsMac;
  logic [7:0] goAddr = 0, address;
  logic [31:0] goData = 0, writedata, readdata, rdata, hashIdWord;
  logic [3:0] deriveSourceSlot, writeAuthSlot;
  logic [23:0] hashIdFixed;
  logic [32:0] e;
  logic [32:0] expQ [$];
  logic [15:0] p;
  logic [15:0] pol [1:6];
  logic [3:0] dl [3] = '{1, 5, 6};
  int errCount = 0, totalChecks = 0, seed = 32'hd7d5_8859;
  // arbitrary fixed id value
  szp_policy #(.ID_FIXED(24'h3C_0F96)) i_szp_policy (.clk, .sys_rst,
    .clkEn(1'b1), .address, .read, .write, .writedata, .byteenable(4'hF),
    .readdata, .waitrequest, .hashIdWord, .hashIdFixed, .useDieId,
    .derivePermit, .deriveNeedsMac, .deriveSourceSlot, .writeNeedsMac,
    .writeAuthSlot);
  szp_host_model i_szp_host_model (.clk, .go, .goWr, .goAddr, .goData,
    .waitrequest, .readdata, .read, .write, .address, .writedata, .done,
    .rdata);
  initial forever #12.5 clk = ~clk;
  function automatic [31:0] arg(input [2:0] o, input [1:0] z,
      input [6:0] x, input [3:0] sl, input b, input m);
    arg = {13'h0000, 1'b0, m, b, sl, x, z, o};
  endfunction
  task automatic check(input [31:0] s, input [31:0] x);
    totalChecks++;
    if (s !== x) begin
      errCount++;
      $display("Error t=%0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic op(input bit wr, input [7:0] a, input [31:0] d,
      input bit c, input [31:0] x);
    int n;
    expQ.push_back({c, x});
    @(posedge clk);
    go <= 1;
    goWr <= wr;
    goAddr <= a;
    goData <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!done && n < 50);
    if (!done) begin
      errCount++;
      $display("Error t=%0t no answer", $time);
    end
    go <= 0;
  endtask
  task automatic cmd(input [31:0] a, input [7:0] st);
    op(1, 8'h04, a, 0, 0);
    op(1, 8'h00, $random(seed), 0, 0);
    op(0, 8'h00, 0, 1, {24'h00_0000, st});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (done && expQ.size() > 0) begin
      e = expQ.pop_front();
      if (e[32]) check(rdata, e[31:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    report_and_stop();
  end
  initial begin
    pol = '{16'h0000, 16'h2080, 16'h8080, 16'h4480, 16'h3280, 16'hA080};
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    op(0, 8'h57, 0, 1, 32'h55);
    op(0, 8'h56, 0, 1, 32'h55);
    op(0, 8'hF0, 0, 1, 0);
    cmd(arg(0, 2, 0, 1, 1, 0), 8'h0F);
    cmd(arg(0, 1, 2, 0, 1, 0), 8'h0F);
    cmd(arg(1, 0, 5, 0, 0, 0), 8'h0F);
    cmd(arg(0, 0, 5, 0, 0, 0), 8'h00);
    cmd(arg(1, 0, 20, 0, 0, 0), 8'h00);
    for (int s = 1; s <= 6; s++) begin
      op(1, 8'h0C, s, 0, 0);
      op(1, 8'h10, pol[s], 0, 0);
    end
    op(0, 8'h10, 0, 1, pol[6]);
    check(hashIdFixed, 24'h3C_0F96);
    $display("config phase done");
    cmd(arg(3, 0, 0, 0, 0, 0), 8'h00);
    op(0, 8'h57, 0, 1, 0);
    cmd(arg(1, 0, 20, 0, 0, 0), 8'h0F);
    cmd(arg(0, 2, 0, 1, 1, 0), 8'h0F);
    cmd(arg(1, 2, 0, 3, 1, 0), 8'h00);
    cmd(arg(1, 1, 3, 0, 0, 0), 8'h00);
    cmd(arg(0, 1, 3, 0, 1, 0), 8'h0F);
    cmd(arg(4, 0, 0, 0, 0, 0), 8'h00);
    $display("lock phase done");
    for (int s = 1; s <= 4; s++) begin
      p = pol[s];
      cmd(arg(1, 2, 0, s, 1, 1), (p[15:13] == 0 || p[14]) ? 0 : 8'h0F);
    end
    check(writeNeedsMac, 1);
    check(writeAuthSlot, 4);
    cmd(arg(1, 2, 0, 4, 1, 0), 8'h0F);
    cmd(arg(1, 2, 0, 4, 0, 1), 8'h0F);
    cmd(arg(0, 2, 0, 6, 0, 0), 8'h0F);
    cmd(arg(0, 2, 0, 6, 1, 0), 8'h0F);
    cmd(arg(0, 2, 0, 1, 1, 0), 8'h00);
    foreach (dl[i]) begin
      p = pol[dl[i]];
      cmd(arg(2, 2, 0, dl[i], 1, 1), p[13] ? 0 : 8'h0F);
      check(derivePermit, p[13]);
      if (p[13]) begin
        check(deriveSourceSlot, p[12] ? p[11:8] : dl[i]);
        check(deriveNeedsMac, p[15]);
      end
    end
    $display("slot phase done");
    cmd(arg(1, 1, 3, 0, 0, 0), 8'h0F);
    cmd(arg(0, 1, 0, 0, 0, 0), 8'h00);
    op(0, 8'h08, 0, 1, 32'hFFFF_FFFF);
    $display("one-time phase done");
    sys_rst <= 1;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    op(0, 8'h57, 0, 1, 32'h55);
    op(1, 8'h18, 32'h1234_5678, 0, 0);
    cmd(arg(0, 0, 5, 0, 0, 0) | 32'h0004_0000, 8'h00);
    check(hashIdWord, 32'h1234_5678);
    check(useDieId, 1);
    op(1, 8'h14, 0, 0, 0);
    cmd(arg(3, 0, 0, 0, 0, 0), 8'h00);
    cmd(arg(4, 0, 0, 0, 0, 0), 8'h00);
    cmd(arg(0, 1, 1, 0, 0, 0), 8'h0F);
    cmd(arg(0, 1, 2, 0, 0, 0), 8'h00);
    cmd(arg(0, 1, 2, 0, 1, 0), 8'h0F);
    cmd(arg(1, 1, 2, 0, 0, 0), 8'h0F);
    $display("legacy phase done");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
